// [core/frpe_top.sv]
// Row program, page erase and mass erase sequencer for two flash arrays, AHB-Lite slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "frpe_params.svh"
module frpe_top
  import frpe_pkg::*;
#(
  parameter int PAGES     = 4,              // Pages per array
  parameter int PROG_CYC  = `FRPE_PROG_CYC, // Row program pulse cycles
  parameter int ERASE_CYC = `FRPE_ERASE_CYC // Page and mass erase cycles
) (
  input  wire logic          clk,          // System clock, 40 MHz
  input  wire logic          rst,          // Async reset, high
  input  wire frpe_ahb_req_t ahb_i,        // AHB-Lite address phase
  input  wire logic [31:0]   hwdata,       // AHB write data
  output logic [31:0]        hrdata,       // AHB read data
  output logic               hreadyout,    // AHB ready
  output logic               hresp,        // AHB response, always OKAY
  output logic               op_busy       // Pulse in progress
);
  localparam int NW = PAGES * `FRPE_PAGE_WORDS;

  // Whole module state
  typedef struct packed {
    frpe_state_t                 st;
    frpe_ctl_t [1:0]             ctl;
    logic [1:0][7:0]             bp;
    logic                        arr;
    logic [4:0]                  page;
    logic                        row;
    logic                        op_prog;
    logic                        op_mass;
    logic                        prot_err;
    logic [`FRPE_ROW_WORDS-1:0][31:0] latch;
    logic [1:0][NW-1:0][31:0]    mem;
    logic                        dph_valid;
    logic                        dph_write;
    frpe_region_t                dph_reg;
    logic [15:0]                 dph_addr;
    logic                        rd_wait;
    logic [31:0]                 hrdata;
    logic [19:0]                 hv_cnt;
  } frpe_core_t;

  frpe_core_t q, d;
  logic       tmr_start;                  // Begin high-voltage pulse
  logic       tmr_abort;                  // Pump dropped early
  logic       tmr_busy;                   // Timer running
  logic       tmr_done;                   // Pulse finished
  logic [1:0] prot;                       // Protect hit per array
  logic [19:0] tmr_load;                  // Pulse length

  // Refuse sizes that the 5-bit page field or the 20-bit pulse timer cannot hold
  if (PAGES < 1 || PAGES > 32) begin : g_bad_pages
    $error("frpe_top: PAGES must be 1..32");
  end
  if (PROG_CYC < 1 || PROG_CYC >= (1 << 20)) begin : g_bad_prog
    $error("frpe_top: PROG_CYC range");
  end
  if (ERASE_CYC < 1 || ERASE_CYC >= (1 << 20)) begin : g_bad_erase
    $error("frpe_top: ERASE_CYC range");
  end

  // Address decode, used only by the address phase capture
  function automatic frpe_region_t frpe_decode(input logic [31:0] a);
    if (a[31:16] != 16'h0) begin
      return FRPE_R_NONE;
    end else if (a[15:0] == `FRPE_CTL1_ADDR) begin
      return FRPE_R_CTL1;
    end else if (a[15:0] == `FRPE_CTL2_ADDR) begin
      return FRPE_R_CTL2;
    end else if (a[15:0] == `FRPE_BP1_ADDR) begin
      return FRPE_R_BP1;
    end else if (a[15:0] == `FRPE_BP2_ADDR) begin
      return FRPE_R_BP2;
    end else if (a[15:0] == `FRPE_STAT_ADDR) begin
      return FRPE_R_STAT;
    end else if (a[15:12] == `FRPE_ARR1_SEL) begin
      return FRPE_R_ARR1;
    end else if (a[15:12] == `FRPE_ARR2_SEL) begin
      return FRPE_R_ARR2;
    end else begin
      return FRPE_R_NONE;
    end
  endfunction

  // Flash word index from page, row and word
  function automatic int frpe_widx(input logic [4:0] pg, input logic rw, input int w);
    return int'(pg) * `FRPE_PAGE_WORDS + int'(rw) * `FRPE_ROW_WORDS + w;
  endfunction

  // One protect checker per array
  genvar ga;
  generate
    for (ga = 0; ga < 2; ga++) begin : g_prot
      frpe_prot u_prot (
        .page (q.page),
        .bp   (q.bp[ga]),
        .mass (q.ctl[ga].mass & q.ctl[ga].erase),
        .prot (prot[ga])
      );
    end
  endgenerate

  // Row pulse sized from the per-byte programming bound
  assign tmr_load = q.ctl[q.arr].pgm ? 20'(PROG_CYC) : 20'(ERASE_CYC);

  // Pulse timer, internal time base
  frpe_timer #(.CW(20)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (tmr_start),
    .abort (tmr_abort),
    .load  (tmr_load),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // Bus, register and sequencer next state
  always_comb begin
    logic        fw;                      // Flash data-phase write
    logic        fa;                      // Array of that write
    logic        in_rng;                  // Page exists
    logic        pump_rise;               // Pump bit just set
    logic [31:0] rv;                      // Read value
    int          wi;                      // Word index
    fw        = 1'b0;
    fa        = 1'b0;
    in_rng    = 1'b0;
    pump_rise = 1'b0;
    rv        = 32'h0;
    wi        = 0;
    d         = q;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    in_rng    = (int'(q.dph_addr[11:7]) < PAGES);
    // Write data phase
    if (q.dph_valid && q.dph_write) begin
      if (q.dph_reg == FRPE_R_CTL1 || q.dph_reg == FRPE_R_CTL2) begin
        fa = (q.dph_reg == FRPE_R_CTL2);
        d.ctl[fa] = {4'h0, hwdata[3:0]};
        pump_rise = hwdata[3] & ~q.ctl[fa].charge_pump_on & (fa == q.arr);
      end else if (q.dph_reg == FRPE_R_BP1) begin
        d.bp[0] = hwdata[7:0];
      end else if (q.dph_reg == FRPE_R_BP2) begin
        d.bp[1] = hwdata[7:0];
      end else if (q.dph_reg == FRPE_R_STAT) begin
        if (hwdata[`FRPE_STAT_W1C_BIT]) begin
          d.prot_err = 1'b0;              // Set below wins
        end
      end else if (q.dph_reg == FRPE_R_ARR1 || q.dph_reg == FRPE_R_ARR2) begin
        fw = in_rng;
        fa = (q.dph_reg == FRPE_R_ARR2);
      end
    end
    // Read data phase, one wait state so hrdata comes from a flop
    if (q.rd_wait) begin
      if (q.dph_reg == FRPE_R_CTL1) begin
        rv = {24'h0, q.ctl[0]};
      end else if (q.dph_reg == FRPE_R_CTL2) begin
        rv = {24'h0, q.ctl[1]};
      end else if (q.dph_reg == FRPE_R_BP1) begin
        rv = {24'h0, q.bp[0]};
      end else if (q.dph_reg == FRPE_R_BP2) begin
        rv = {24'h0, q.bp[1]};
      end else if (q.dph_reg == FRPE_R_STAT) begin
        rv = {28'h0, q.st == FRPE_HOLD, q.prot_err, q.st == FRPE_ARMED, q.st == FRPE_BUSY};
      end else if (q.dph_reg == FRPE_R_ARR1 || q.dph_reg == FRPE_R_ARR2) begin
        // Missing pages read as erased
        rv = in_rng ? q.mem[q.dph_reg == FRPE_R_ARR2][q.dph_addr[11:2]] : 32'hffff_ffff;
      end
      d.hrdata  = rv;
      d.rd_wait = 1'b0;
    end
    // Sequencer
    case (q.st)
      FRPE_IDLE: begin
        // Dummy write picks the page and clears the row latch
        if (fw && (d.ctl[fa].pgm ^ d.ctl[fa].erase)) begin
          d.arr   = fa;
          d.page  = q.dph_addr[11:7];
          d.row   = q.dph_addr[6];
          d.latch = '1;
          d.st    = FRPE_ARMED;
        end
      end
      FRPE_ARMED: begin
        if (fw && fa == q.arr && q.dph_addr[11:7] == q.page && q.ctl[q.arr].pgm) begin
          d.latch[q.dph_addr[5:2]] = hwdata;
          d.row                    = q.dph_addr[6];
        end
        if (!(d.ctl[q.arr].pgm | d.ctl[q.arr].erase)) begin
          d.st = FRPE_IDLE;
        end else if (pump_rise) begin
          if (prot[q.arr]) begin
            d.prot_err = 1'b1;
            d.st       = FRPE_HOLD;
          end else begin
            tmr_start = 1'b1;
            d.op_prog = d.ctl[q.arr].pgm;
            d.op_mass = d.ctl[q.arr].erase & d.ctl[q.arr].mass;
            d.hv_cnt  = 20'h0;
            d.st      = FRPE_BUSY;
          end
        end
      end
      FRPE_BUSY: begin
        d.hv_cnt = q.hv_cnt + 20'h1;
        if (!d.ctl[q.arr].charge_pump_on) begin
          tmr_abort = 1'b1;               // Early pump off, array untouched
          d.st      = FRPE_IDLE;
        end else if (tmr_done) begin
          if (q.op_prog) begin
            for (int w = 0; w < `FRPE_ROW_WORDS; w++) begin
              wi = frpe_widx(q.page, q.row, w);
              d.mem[q.arr][wi] = q.mem[q.arr][wi] & q.latch[w];
            end
          end else if (q.op_mass) begin
            d.mem[q.arr] = '1;
          end else begin
            for (int w = 0; w < `FRPE_PAGE_WORDS; w++) begin
              wi = frpe_widx(q.page, 1'b0, w);
              d.mem[q.arr][wi] = 32'hffff_ffff;
            end
          end
          d.st = FRPE_HOLD;
        end
      end
      FRPE_HOLD: begin
        // Leaves when software drops the pump
        if (!d.ctl[q.arr].charge_pump_on) begin
          d.st = FRPE_IDLE;
        end
      end
      default: begin
        d.st = FRPE_IDLE;
      end
    endcase
    // Address phase capture
    if (hreadyout) begin
      d.dph_valid = 1'b0;
      if (ahb_i.hsel && ahb_i.htrans[1]) begin
        d.dph_valid = 1'b1;
        d.dph_write = ahb_i.hwrite;
        d.dph_reg   = frpe_decode(ahb_i.haddr);
        d.dph_addr  = ahb_i.haddr[15:0];
        d.rd_wait   = ~ahb_i.hwrite;
      end
    end
  end

  // State register; the array powers up erased
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.st      <= FRPE_IDLE;
      q.ctl     <= '0;
      q.bp      <= {`FRPE_BP_RST, `FRPE_BP_RST};
      q.latch   <= '1;
      q.mem     <= '1;
      q.dph_reg <= FRPE_R_NONE;
    end else begin
      q <= d;
    end
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = ~q.rd_wait;
  assign hresp     = 1'b0;
  assign op_busy   = tmr_busy;

  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pulse_end;
    q.st == FRPE_BUSY && tmr_done && d.ctl[q.arr].charge_pump_on;
  endsequence

  property p_ctl_high_zero;
    q.ctl[0].unused == 4'h0 && q.ctl[1].unused == 4'h0;
  endproperty
  a_ctl_high_zero: assert property (p_ctl_high_zero) else $error("ctl high bits set");

  property p_ctl1_decode;
    (ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hwrite && hreadyout
      && ahb_i.haddr == {16'h0, `FRPE_CTL1_ADDR})
      ##1 1'b1 |=> q.ctl[0] == {4'h0, $past(hwdata[3:0])};
  endproperty
  a_ctl1_decode: assert property (p_ctl1_decode) else $error("ctl1 not written");

  property p_row_program;
    s_pulse_end and q.op_prog |=>
      q.mem[q.arr][frpe_widx(q.page, q.row, 15)] ==
      ($past(q.mem[q.arr][frpe_widx(q.page, q.row, 15)]) & $past(q.latch[15]));
  endproperty
  a_row_program: assert property (p_row_program) else $error("row program wrong");

  property p_page_erase;
    s_pulse_end and !q.op_prog |=>
      q.mem[q.arr][frpe_widx(q.page, 1'b1, 15)] == 32'hffff_ffff;
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page not erased");

  property p_mass_erase;
    s_pulse_end and q.op_mass |=> q.mem[q.arr][NW-1] == 32'hffff_ffff;
  endproperty
  a_mass_erase: assert property (p_mass_erase) else $error("mass erase missed");

  property p_prog_time;
    q.st == FRPE_BUSY && q.op_prog |-> int'(q.hv_cnt) <= PROG_CYC;
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program pulse too long");

  property p_protect_refuse;
    q.st == FRPE_ARMED && tmr_start |-> !prot[q.arr];
  endproperty
  a_protect_refuse: assert property (p_protect_refuse) else $error("protected op ran");

  property p_protect_flag;
    q.st == FRPE_ARMED && prot[q.arr] && d.st == FRPE_HOLD |=> q.prot_err && !tmr_busy;
  endproperty
  a_protect_flag: assert property (p_protect_flag) else $error("refusal not flagged");

  property p_page_range;
    q.st != FRPE_IDLE |-> int'(q.page) < PAGES;
  endproperty
  a_page_range: assert property (p_page_range) else $error("page out of range");

  property p_read_wait;
    q.rd_wait |-> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
endmodule // frpe_top

// [core/frpe_params.svh]
// Address map, field positions, reset values and timing figures of the flash sequencer
`ifndef FRPE_PARAMS_SVH
`define FRPE_PARAMS_SVH
`define FRPE_CTL1_ADDR    16'hff88
`define FRPE_CTL2_ADDR    16'hfe08
`define FRPE_BP1_ADDR     16'hff80
`define FRPE_BP2_ADDR     16'hfe00
`define FRPE_STAT_ADDR    16'hff84
`define FRPE_ARR1_SEL     4'h1
`define FRPE_ARR2_SEL     4'h2
`define FRPE_CTL_RST      4'h0
`define FRPE_BP_RST       8'hff
`define FRPE_BP_NONE      8'hff
`define FRPE_STAT_W1C_BIT 2
`define FRPE_PAGE_BYTES   128
`define FRPE_ROW_BYTES    64
`define FRPE_ROW_WORDS    16
`define FRPE_PAGE_WORDS   32
`define FRPE_CLK_MHZ      40
`define FRPE_BYTE_PROG_US 40
`define FRPE_ERASE_US     1000
`define FRPE_PROG_CYC     (`FRPE_ROW_BYTES * `FRPE_BYTE_PROG_US * `FRPE_CLK_MHZ)
`define FRPE_ERASE_CYC    (`FRPE_ERASE_US * `FRPE_CLK_MHZ)
`endif

// [core/frpe_pkg.sv]
// Types shared by the flash sequencer modules
package frpe_pkg;
  // Control register layout, bits 7:4 have no function
  typedef struct packed {
    logic [3:0] unused;
    logic       charge_pump_on;
    logic       mass;
    logic       erase;
    logic       pgm;
  } frpe_ctl_t;

  // AHB-Lite address phase as seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } frpe_ahb_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    FRPE_IDLE  = 2'b00,
    FRPE_ARMED = 2'b01,
    FRPE_BUSY  = 2'b10,
    FRPE_HOLD  = 2'b11
  } frpe_state_t;

  // Decoded register regions
  typedef enum logic [2:0] {
    FRPE_R_NONE = 3'b000,
    FRPE_R_CTL1 = 3'b001,
    FRPE_R_CTL2 = 3'b010,
    FRPE_R_BP1  = 3'b011,
    FRPE_R_BP2  = 3'b100,
    FRPE_R_STAT = 3'b101,
    FRPE_R_ARR1 = 3'b110,
    FRPE_R_ARR2 = 3'b111
  } frpe_region_t;
endpackage

// [core/frpe_timer.sv]
// High-voltage pulse timer, counts down a loaded cycle figure
`timescale 1ns/10ps
module frpe_timer
  import frpe_pkg::*;
#(
  parameter int CW = 20                 // Counter width
) (
  input  wire logic          clk,       // System clock
  input  wire logic          rst,       // Async reset, high
  input  wire logic          start,     // Load and run
  input  wire logic          abort,     // Stop without done
  input  wire logic [CW-1:0] load,      // Cycles to run
  output logic               busy,      // Counting
  output logic               done       // One-cycle end pulse
);
  // Counter and run flag in one register
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          run;
    logic          fin;
  } frpe_tmr_t;

  frpe_tmr_t q, d;

  // Counter must fit the int-based load figures
  if (CW < 2 || CW > 31) begin : g_bad_cw
    $error("frpe_timer: CW out of range");
  end

  // Next state: pulse internally clocked, no software clock select
  always_comb begin
    d     = q;
    d.fin = 1'b0;
    if (abort) begin
      d.run = 1'b0;
    end else if (start) begin
      d.cnt = load;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt <= CW'(1)) begin
        d.run = 1'b0;
        d.fin = 1'b1;
      end else begin
        d.cnt = q.cnt - CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.run;
  assign done = q.fin;
endmodule // frpe_timer

// [core/frpe_prot.sv]
// Block-protect check of one page against one protect register
`timescale 1ns/10ps
`include "frpe_params.svh"
module frpe_prot
  import frpe_pkg::*;
(
  input  wire logic [4:0] page,         // Page index in array
  input  wire logic [7:0] bp,           // Protect register, page granular
  input  wire logic       mass,         // Whole-array operation
  output logic            prot          // Operation refused
);
  // Pages from bp upward are protected, all ones protects nothing
  always_comb begin
    if (bp == `FRPE_BP_NONE) begin
      prot = 1'b0;
    end else if (mass) begin
      prot = 1'b1;
    end else begin
      prot = ({3'h0, page} >= bp);
    end
  end
endmodule // frpe_prot

// [tb/flash_row_page_program_erase_tb_top.sv]
// Self-checking bench of the row program, page erase and mass erase sequencer
`timescale 1ns/10ps
`include "frpe_params.svh"
module flash_row_page_program_erase_tb_top
  import frpe_pkg::*;
;
  localparam int          PC = 20;                        // Short program pulse
  localparam int          EC = 30;                        // Short erase pulse
  localparam logic [31:0] C1 = {16'h0000, `FRPE_CTL1_ADDR}; // Array 1 control
  localparam logic [31:0] C2 = {16'h0000, `FRPE_CTL2_ADDR}; // Array 2 control
  localparam logic [31:0] B1 = {16'h0000, `FRPE_BP1_ADDR};  // Array 1 protect
  localparam logic [31:0] B2 = {16'h0000, `FRPE_BP2_ADDR};  // Array 2 protect
  localparam logic [31:0] ST = {16'h0000, `FRPE_STAT_ADDR}; // Status
  localparam logic [31:0] ONES = 32'hffffffff;            // Erased word
  logic          clk;                                     // 40 MHz clock
  logic          rst;                                     // Async reset, high
  frpe_ahb_req_t ahb_i;                                   // Address phase
  logic [31:0]   hwdata;                                  // Write data
  logic [31:0]   hrdata;                                  // Read data
  logic          hreadyout;                               // Slave ready
  logic          hresp;                                   // Response
  logic          op_busy;                                 // Pulse running
  int            err_count;                               // Mismatches
  int            num_checks;                              // Comparisons
  int            cyc = 0;                                 // Watchdog count
  int            len;                                     // Pulse length
  logic [31:0]   rd;                                      // Last read word

  frpe_top #(.PAGES(4), .PROG_CYC(PC), .ERASE_CYC(EC)) frpe_top_inst (
    .clk(clk), .rst(rst), .ahb_i(ahb_i), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_busy(op_busy));

  // Free running clock, 25 ns period
  always #12.5 clk = ~clk;

  // Watchdog, far above the fewer than a thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One comparison, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Look at ready before each edge, so the edge that samples it high ends the wait
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    chk(32'(n < 20), 32'h1, "ready never came");
    d = hrdata;
    @(posedge clk);
  endtask

  // Single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb_i <= '{hsel: 1'b1, haddr: a, htrans: 2'b10, hwrite: w, hsize: 3'b010};
    wait_rdy(d);
    ahb_i.htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(d);
    rd = d;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  // Raise the pump, time the pulse, check done and error flags, drop the pump
  task automatic pulse(input logic [31:0] ca, input logic [31:0] v, input logic [31:0] es);
    int n;
    n = 0;
    len = 0;
    wr(ca, v);
    while (op_busy !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    while (op_busy === 1'b1 && len < 2000) begin
      @(negedge clk);
      len++;
    end
    @(posedge clk);
    xfer(1'b0, ST, 32'h0);
    chk(rd & 32'h0000000c, es, "status flags");
    wr(ca, 32'h0);
    repeat (4) @(posedge clk);
  endtask

  // Fill one row from a pattern, one pass only
  task automatic prog_row(input logic [31:0] ca, input logic [31:0] b, input logic [31:0] p);
    wr(ca, 32'h1);
    wr(b, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(b + 32'(4 * i), p ^ 32'(i));
    end
    pulse(ca, 32'h9, 32'h8);
    chk(32'(len >= PC - 1 && len <= PC + 1), 32'h1, "program time");
  endtask

  task automatic rowchk(input logic [31:0] b, input logic [31:0] p);
    for (int i = 0; i < 16; i++) begin
      rdchk(b + 32'(4 * i), p ^ 32'(i), "row word");
    end
  endtask

  // Values after reset, erased array, unmapped place
  task automatic t_reset();
    rdchk(C1, 32'h0, "ctl1 reset");
    rdchk(C2, 32'h0, "ctl2 reset");
    rdchk(B1, 32'hff, "bp1 reset");
    rdchk(B2, 32'hff, "bp2 reset");
    rdchk(ST, 32'h0, "status reset");
    rdchk(32'h00001000, ONES, "erased reads ones");
    rdchk(32'h00002ffc, ONES, "erased reads ones");
    rdchk(32'h0001ff88, 32'h0, "unmapped read");
    chk(32'(hresp), 32'h0, "hresp");
    $display("test reset done");
  endtask

  // Upper control bits dead, bit 2 kept as mass select
  task automatic t_ctl();
    logic [31:0] a [2];
    a[0] = C1;
    a[1] = C2;
    foreach (a[k]) begin
      wr(a[k], 32'hf0);
      rdchk(a[k], 32'h0, "unused bits");
      wr(a[k], 32'h04);
      rdchk(a[k], 32'h04, "mass bit");
      wr(a[k], 32'h0);
    end
    $display("test control bits done");
  endtask

  // Two rows in two pages, then erase only the second page
  task automatic t_prog_erase();
    prog_row(C1, 32'h00001000, 32'h5a5a0f00);
    prog_row(C1, 32'h000010c0, 32'h3c3c00f0);
    rowchk(32'h00001000, 32'h5a5a0f00);
    rowchk(32'h000010c0, 32'h3c3c00f0);
    rdchk(32'h00001080, ONES, "other row untouched");
    rdchk(32'h00001040, ONES, "other row untouched");
    wr(C1, 32'h2);
    wr(32'h00001084, 32'h0);
    pulse(C1, 32'ha, 32'h8);
    chk(32'(len >= EC - 1 && len <= EC + 1), 32'h1, "erase time");
    rdchk(32'h000010c0, ONES, "page erased");
    rdchk(32'h000010fc, ONES, "page erased");
    rowchk(32'h00001000, 32'h5a5a0f00);
    $display("test program erase done");
  endtask

  // Protected page and mass erase refused, error flag cleared by write one
  task automatic t_protect();
    wr(B1, 32'h01);
    rdchk(B1, 32'h01, "bp1 write");
    wr(C1, 32'h1);
    wr(32'h00001080, 32'h0);
    wr(32'h00001080, 32'h0);
    pulse(C1, 32'h9, 32'hc);
    chk(32'(len), 32'h0, "no pulse");
    rdchk(32'h00001080, ONES, "protected page kept");
    wr(ST, 32'h4);
    xfer(1'b0, ST, 32'h0);
    chk(rd & 32'h4, 32'h0, "error cleared");
    wr(C1, 32'h6);
    wr(32'h00001000, 32'h0);
    pulse(C1, 32'he, 32'hc);
    chk(32'(len), 32'h0, "no mass pulse");
    rowchk(32'h00001000, 32'h5a5a0f00);
    wr(ST, 32'h4);
    wr(B1, 32'hff);
    $display("test protect done");
  endtask

  // Mass erase of the second array leaves the first alone
  task automatic t_mass();
    prog_row(C2, 32'h00002100, 32'h0ff0a500);
    rowchk(32'h00002100, 32'h0ff0a500);
    wr(C2, 32'h6);
    wr(32'h00002000, 32'h0);
    pulse(C2, 32'he, 32'h8);
    chk(32'(len >= EC - 1 && len <= EC + 1), 32'h1, "mass time");
    rdchk(32'h00002100, ONES, "mass erased");
    rdchk(32'h0000213c, ONES, "mass erased");
    rdchk(32'h00001000, 32'h5a5a0f00, "array 1 kept");
    $display("test mass erase done");
  endtask

  // Reset for three cycles, then the tests in turn
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ahb_i = '0;
    hwdata = '0;
    err_count = 0;
    num_checks = 0;
    len = 0;
    rd = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ctl();
    t_prog_erase();
    t_protect();
    t_mass();
    end_of_test();
  end
endmodule // flash_row_page_program_erase_tb_top
